// File: verilog/bpc_defines.vh
// register map, field positions and reset values for the pin group
`ifndef BPC_DEFINES_VH
`define BPC_DEFINES_VH
`define BPC_ADDR_W 12
`define BPC_OFS_DATA 12'h000
`define BPC_OFS_DIR 12'h004
`define BPC_OFS_OPTION 12'h008
`define BPC_OFS_IRQCTL 12'h00C
`define BPC_OFS_STATUS 12'h010
`define BPC_OFS_MASK 12'h014
`define BPC_PULLUP_BIT 7
`define BPC_CHG_BIT 0
`define BPC_UPPER_LO 4
`define BPC_UPPER_HI 7
`define BPC_DIR_RST 8'hFF
`define BPC_OPTION_RST 8'hFF
`define BPC_ZERO8 8'h00
`define BPC_ZERO32 32'h00000000
`define BPC_STAT_RST 2'h0
`define BPC_MASK_RST 2'h0
`define BPC_EV_CHG 0
`define BPC_EV_WAKE 1
`define BPC_PIN_COUNT 8
`define BPC_STAT_COUNT 2
`define BPC_STAT_HI 1
`define BPC_STAT_LO 0
`define BPC_BIT_CLR 1'h0
`define BPC_BIT_SET 1'h1
`endif

// File: verilog/bpc_port.v
// eight-bit bidirectional pin group with change interrupt and APB registers
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "bpc_defines.vh"
module bpc_port (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [7:0] PIN_IN,
  output wire [7:0] PIN_OUT,
  output wire [7:0] PIN_OE_N,
  output wire [7:0] PULLUP_ON,
  input wire SLEEP_ACTIVE,
  output wire WAKE,
  output wire IRQ
);
  reg [7:0] sync1_reg;
  reg [7:0] pins_reg;
  reg [7:0] latch_reg;
  reg [7:0] dir_reg;
  reg [7:0] option_reg;
  reg [3:0] snap_reg;
  reg chg_flag_reg;
  reg [1:0] stat_reg;
  reg [1:0] mask_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [7:0] latch_next;
  wire acc;
  wire wr;
  wire rd;
  wire data_acc;
  wire [3:0] upper_in;
  wire [3:0] mismatch;
  wire chg_set;
  wire [1:0] ev;
  genvar g;

  function sel;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  // read data is captured in the setup cycle so it stands through the access phase
  assign rd = PSEL & ~PENABLE & ~PWRITE;
  assign PREADY = `BPC_BIT_SET;
  assign PSLVERR = acc & ~(sel(PADDR, `BPC_OFS_DATA) | sel(PADDR, `BPC_OFS_DIR) |
    sel(PADDR, `BPC_OFS_OPTION) | sel(PADDR, `BPC_OFS_IRQCTL) | sel(PADDR, `BPC_OFS_STATUS) |
    sel(PADDR, `BPC_OFS_MASK));
  assign PRDATA = rdata_reg;
  assign data_acc = acc & sel(PADDR, `BPC_OFS_DATA);

  // per-pin drive and pull-up
  generate
    for (g = 0; g < `BPC_PIN_COUNT; g = g + 1) begin : g_pin
      assign PIN_OE_N[g] = dir_reg[g];
      assign PIN_OUT[g] = latch_reg[g];
      assign PULLUP_ON[g] = ~option_reg[`BPC_PULLUP_BIT] & dir_reg[g];
    end
  endgenerate

  assign upper_in = pins_reg[`BPC_UPPER_HI:`BPC_UPPER_LO];
  assign mismatch = (upper_in ^ snap_reg) & dir_reg[`BPC_UPPER_HI:`BPC_UPPER_LO];
  // access cycle refreshes the snapshot, so a change then is absorbed
  assign chg_set = (|mismatch) & ~data_acc;
  assign ev[`BPC_EV_CHG] = chg_set;
  assign ev[`BPC_EV_WAKE] = chg_set & SLEEP_ACTIVE;
  assign WAKE = chg_flag_reg;
  assign IRQ = |(stat_reg & mask_reg);

  always @* begin
    latch_next = latch_reg;
    if (wr & sel(PADDR, `BPC_OFS_DATA)) begin
      // byte writes load the written value straight into the latch, input pins included
      latch_next = PWDATA[7:0];
    end
  end

  always @* begin
    rdata_next = `BPC_ZERO32;
    if (sel(PADDR, `BPC_OFS_DATA)) begin
      rdata_next[7:0] = pins_reg;
    end else if (sel(PADDR, `BPC_OFS_DIR)) begin
      rdata_next[7:0] = dir_reg;
    end else if (sel(PADDR, `BPC_OFS_OPTION)) begin
      rdata_next[7:0] = option_reg;
    end else if (sel(PADDR, `BPC_OFS_IRQCTL)) begin
      rdata_next[`BPC_CHG_BIT] = chg_flag_reg;
    end else if (sel(PADDR, `BPC_OFS_STATUS)) begin
      rdata_next[1:0] = stat_reg;
    end else if (sel(PADDR, `BPC_OFS_MASK)) begin
      rdata_next[1:0] = mask_reg;
    end
  end

  // register hit decode, one strobe per register except data
  wire hit_dir;
  wire hit_option;
  wire hit_irqctl;
  wire hit_status;
  wire hit_mask;
  wire wr_dir;
  wire wr_option;
  wire wr_irqctl;
  wire wr_status;
  wire wr_mask;
  wire flag_clr;
  wire [1:0] stat_keep;
  wire [1:0] stat_next;
  wire [3:0] snap_next;
  wire [7:0] dir_next;
  wire [7:0] option_next;
  wire [1:0] mask_next;

  assign hit_dir = sel(PADDR, `BPC_OFS_DIR);
  assign hit_option = sel(PADDR, `BPC_OFS_OPTION);
  assign hit_irqctl = sel(PADDR, `BPC_OFS_IRQCTL);
  assign hit_status = sel(PADDR, `BPC_OFS_STATUS);
  assign hit_mask = sel(PADDR, `BPC_OFS_MASK);

  assign wr_dir = wr & hit_dir;
  assign wr_option = wr & hit_option;
  assign wr_irqctl = wr & hit_irqctl;
  assign wr_status = wr & hit_status;
  assign wr_mask = wr & hit_mask;

  // only a written zero clears, a written one leaves the flag alone
  assign flag_clr = wr_irqctl & ~PWDATA[`BPC_CHG_BIT];

  // write-one-clear first, then new events, so a set in the same cycle wins
  assign stat_keep = wr_status ? (stat_reg & ~PWDATA[`BPC_STAT_HI:`BPC_STAT_LO]) : stat_reg;
  assign stat_next = stat_keep | ev;

  // snapshot follows the pins only on a data access, read or write
  assign snap_next = data_acc ? upper_in : snap_reg;

  assign dir_next = wr_dir ? PWDATA[7:0] : dir_reg;
  assign option_next = wr_option ? PWDATA[7:0] : option_reg;
  assign mask_next = wr_mask ? PWDATA[`BPC_STAT_HI:`BPC_STAT_LO] : mask_reg;

  // two-flop synchroniser per pin; only the second stage feeds logic
  generate
    for (g = 0; g < `BPC_PIN_COUNT; g = g + 1) begin : g_sync
      always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          sync1_reg[g] <= `BPC_BIT_CLR;
          pins_reg[g] <= `BPC_BIT_CLR;
        end else begin
          sync1_reg[g] <= PIN_IN[g];
          pins_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  // output latch per pin
  generate
    for (g = 0; g < `BPC_PIN_COUNT; g = g + 1) begin : g_latch
      always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          latch_reg[g] <= `BPC_BIT_CLR;
        end else begin
          latch_reg[g] <= latch_next[g];
        end
      end
    end
  endgenerate

  // direction per pin, every pin an input after reset
  generate
    for (g = 0; g < `BPC_PIN_COUNT; g = g + 1) begin : g_dir
      always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          dir_reg[g] <= `BPC_BIT_SET;
        end else begin
          dir_reg[g] <= dir_next[g];
        end
      end
    end
  endgenerate

  // option word; its top bit gates all pull-ups
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      option_reg <= `BPC_OPTION_RST;
    end else begin
      option_reg <= option_next;
    end
  end

  // snapshot of the upper pins
  generate
    for (g = `BPC_UPPER_LO; g <= `BPC_UPPER_HI; g = g + 1) begin : g_snap
      always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          snap_reg[g - `BPC_UPPER_LO] <= `BPC_BIT_CLR;
        end else begin
          snap_reg[g - `BPC_UPPER_LO] <= snap_next[g - `BPC_UPPER_LO];
        end
      end
    end
  endgenerate

  // read data register, loaded in the setup cycle
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= `BPC_ZERO32;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // change flag: a persisting mismatch keeps it set against a clear
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      chg_flag_reg <= `BPC_BIT_CLR;
    end else if (chg_set) begin
      chg_flag_reg <= `BPC_BIT_SET;
    end else if (flag_clr) begin
      chg_flag_reg <= `BPC_BIT_CLR;
    end
  end

  // sticky status and its mask, one bit per event
  generate
    for (g = 0; g < `BPC_STAT_COUNT; g = g + 1) begin : g_stat
      always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          stat_reg[g] <= `BPC_BIT_CLR;
          mask_reg[g] <= `BPC_BIT_CLR;
        end else begin
          stat_reg[g] <= stat_next[g];
          mask_reg[g] <= mask_next[g];
        end
      end
    end
  endgenerate
endmodule // bpc_port
`default_nettype wire

// File: dv/bpc_port_asserts.sv
// checker for the pin group port
`timescale 1ns/10ps
`default_nettype none
module bpc_port_asserts (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [7:0] PIN_OUT,
  input wire [7:0] PIN_OE_N,
  input wire [7:0] PULLUP_ON,
  input wire WAKE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_wr; PSEL && PENABLE && PWRITE; endsequence
  a_pull_outs: assert property (!(PULLUP_ON & ~PIN_OE_N)) else $error("pull on output");
  a_pull_all: assert property (PULLUP_ON == 8'h00 || PULLUP_ON == PIN_OE_N) else $error("pulls");
  a_dir_take: assert property (s_wr ##0 PADDR == 12'h004 |=> PIN_OE_N == $past(PWDATA[7:0])) else $error("dir");
  a_out_take: assert property (s_wr ##0 PADDR == 12'h000 |=> PIN_OUT == $past(PWDATA[7:0])) else $error("out");
  a_dir_hold: assert property (!(PSEL && PWRITE && PADDR == 12'h004) |=> $stable(PIN_OE_N)) else $error("oe");
  a_wake_held: assert property (WAKE && !(PSEL && PADDR == 12'h00C) |=> WAKE) else $error("wake");
  a_err_setup: assert property (PSEL && !PENABLE |-> !PSLVERR) else $error("slverr");
  a_ready_high: assert property (PSEL && PENABLE |-> PREADY) else $error("ready");
endmodule // bpc_port_asserts
`default_nettype wire

// File: dv/bpc_pins_model.sv
// pin side: latch drive, pull-ups, outside drive
`timescale 1ns/10ps
`default_nettype none
module bpc_pins_model (
  input wire [7:0] ext,
  input wire [7:0] ext_en,
  input wire [7:0] pin_out,
  input wire [7:0] oe_n,
  input wire [7:0] pull_on,
  output wire [7:0] level
);
  // floating pin without pull-up shows a flipped value
  assign level = (~oe_n & pin_out) | (oe_n & ((ext_en & ext) | (~ext_en & (pull_on | ~ext))));
endmodule // bpc_pins_model
`default_nettype wire

// File: dv/bidir_port_with_change_irq_tb_top.sv
// self-checking bench for the pin group port
`timescale 1ns/10ps
`default_nettype none
module bidir_port_with_change_irq_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, slp = 0, prdy, perr, wake, irq, e;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic [7:0] ext = 0, xen = 8'hFF, po, poe, pu, pin;
  int bad_count = 0, cmp_count = 0;
  logic [31:0] rows [3] = '{32'hFF00A5A5, 32'h003CFF3C, 32'h0FA005A5};
  always #2.5 clk = ~clk;
  bpc_port u_bpc_port (.SYS_CLK(clk), .ARST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .PIN_IN(pin), .PIN_OUT(po), .PIN_OE_N(poe),
    .PULLUP_ON(pu), .SLEEP_ACTIVE(slp), .WAKE(wake), .IRQ(irq));
  bpc_pins_model u_bpc_pins_model (.ext(ext), .ext_en(xen), .pin_out(po), .oe_n(poe), .pull_on(pu), .level(pin));
  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  task ap(input w, input [11:0] a, input [31:0] d);
    int i;
    @(posedge clk) begin psel <= 1; pwr <= w; pa <= a; pwd <= d; end
    @(posedge clk) pen <= 1;
    i = 0;
    do begin @(posedge clk); e = perr; rd = prd; i++; end while (prdy !== 1'b1 && i < 20);
    if (prdy !== 1'b1) begin chk(0, 1); give_verdict; end
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task wt;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk(poe, 8'hFF);
    chk(pu, 8'h00);
    foreach (rows[k]) begin
      ext <= rows[k][15:8];
      ap(1, 12'h004, rows[k][31:24]);
      ap(1, 12'h000, rows[k][23:16]);
      ap(0, 12'h000, 0);
      chk(rd, rows[k][7:0]);
    end
    xen <= 8'h00;
    ap(1, 12'h008, 8'h7F);
    ap(0, 12'h000, 0);
    chk(pu, 8'h0F);
    chk(rd, 8'hAF);
    ap(1, 12'h008, 8'hFF);
    xen <= 8'hFF;
    ext <= 8'h00;
    slp <= 1;
    ap(1, 12'h004, 8'hFF);
    ap(0, 12'h000, 0);
    ap(1, 12'h00C, 0);
    ext <= 8'h0F;
    wt;
    chk(wake, 0);
    ext <= 8'h1F;
    wt;
    chk(wake, 1);
    chk(irq, 0);
    ap(1, 12'h014, 3);
    chk(irq, 1);
    ap(1, 12'h00C, 0);
    ap(0, 12'h00C, 0);
    chk(rd[0], 1);
    ap(0, 12'h000, 0);
    ap(1, 12'h00C, 0);
    ap(0, 12'h00C, 0);
    chk(rd[0], 0);
    ap(0, 12'h010, 0);
    chk(rd, 3);
    ap(1, 12'h010, 3);
    chk(irq, 0);
    ap(0, 12'h018, 0);
    chk(e, 1);
    chk(rd, 0);
    give_verdict;
  end
endmodule // bidir_port_with_change_irq_tb_top
bind bpc_port bpc_port_asserts u_bpc_port_asserts (.*);
`default_nettype wire
